// ==== i2c_irq_common.sv ====
`timescale 1ns/1ps
`default_nettype none

package i2c_irq_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam int unsigned ADDR_W         = 4;
	localparam logic [3:0]  ADDR_CTRL      = 4'h0;
	localparam logic [3:0]  ADDR_EV_STATUS = 4'h4;
	localparam logic [3:0]  ADDR_EV_MASK   = 4'h8;
	localparam int unsigned DATA_W         = 8;
	// ----------------------------------------
	// control register fields
	// ----------------------------------------
	localparam int unsigned BIT_TX_EMPTY_EN = 7;
	localparam int unsigned BIT_TX_END_EN   = 6;
	localparam int unsigned BIT_RX_FULL_EN  = 5;
	localparam int unsigned BIT_NACK_EN     = 4;
	localparam int unsigned BIT_STOP_EN     = 3;
	localparam int unsigned BIT_ACK_JUDGE   = 2;
	localparam int unsigned BIT_RX_ACK      = 1;
	localparam int unsigned BIT_TX_ACK      = 0;
	localparam logic [7:0]  CTRL_RESET      = 8'h00;
	localparam logic [7:0]  CTRL_WR_MASK    = 8'hfd;
	// ----------------------------------------
	// event status and mask layout
	// ----------------------------------------
	localparam int unsigned NUM_EV       = 6;
	localparam int unsigned EV_TX_EMPTY  = 0;
	localparam int unsigned EV_TX_END    = 1;
	localparam int unsigned EV_RX_FULL   = 2;
	localparam int unsigned EV_ERROR     = 3;
	localparam int unsigned EV_NACK      = 4;
	localparam int unsigned EV_STOP      = 5;
	localparam logic [5:0]  EV_RESET     = 6'h00;
endpackage : i2c_irq_pkg

module req_gate (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic flag,
	input  wire logic enable,
	output var  logic req
);
	// ----------------------------------------
	// level request: flag and enable, registered
	// ----------------------------------------
	wire req_next = flag & enable;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			req <= 1'b0;
		end else begin
			req <= req_next;
		end
	end
endmodule : req_gate

`default_nettype wire

// ==== i2c_irq_enable_gating.sv ====
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module i2c_irq_enable_gating
	import i2c_irq_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output var  logic [DATA_W-1:0] reg_rdata,
	input  wire logic              tx_buf_empty_flag,
	input  wire logic              tx_end_flag,
	input  wire logic              rx_buf_full_flag,
	input  wire logic              nack_detect_flag,
	input  wire logic              arb_lost_flag,
	input  wire logic              overrun_flag,
	input  wire logic              stop_detect_flag,
	input  wire logic              sync_mode,
	input  wire logic              tx_mode,
	input  wire logic              ack_slot,
	input  wire logic              sda_in,
	output var  logic              sda_out,
	output var  logic              sda_oe_n,
	output var  logic              halt_transfer,
	output logic                   tx_empty_req,
	output logic                   tx_end_req,
	output logic                   rx_full_req,
	output logic                   error_req,
	output logic                   nack_req,
	output logic                   stop_detect_req,
	output var  logic              irq
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [7:0]        ctrl_reg;
	logic [7:0]        ctrl_next;
	logic [NUM_EV-1:0] ev_status_reg;
	logic [NUM_EV-1:0] ev_status_next;
	logic [NUM_EV-1:0] ev_mask_reg;
	logic [NUM_EV-1:0] ev_mask_next;
	logic [NUM_EV-1:0] req_prev_reg;
	logic [DATA_W-1:0] rdata_next;
	logic              sda_meta_reg;
	logic              sda_sync_reg;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	wire hit_ctrl   = (reg_addr == ADDR_CTRL);
	wire hit_status = (reg_addr == ADDR_EV_STATUS);
	wire hit_mask   = (reg_addr == ADDR_EV_MASK);
	wire wr_ctrl    = reg_wr & hit_ctrl;
	wire wr_status  = reg_wr & hit_status;
	wire wr_mask    = reg_wr & hit_mask;

	// ----------------------------------------
	// enable bits
	// ----------------------------------------
	wire tx_empty_irq_en   = ctrl_reg[BIT_TX_EMPTY_EN];
	wire tx_end_irq_en     = ctrl_reg[BIT_TX_END_EN];
	wire rx_full_irq_en    = ctrl_reg[BIT_RX_FULL_EN];
	wire nack_irq_en       = ctrl_reg[BIT_NACK_EN];
	wire stop_detect_irq_en = ctrl_reg[BIT_STOP_EN];
	wire ack_judge_sel     = ctrl_reg[BIT_ACK_JUDGE];
	wire rx_ack_value      = ctrl_reg[BIT_RX_ACK];
	wire tx_ack_value      = ctrl_reg[BIT_TX_ACK];

	// ----------------------------------------
	// request sources
	// ----------------------------------------
	wire sync_overrun  = sync_mode & overrun_flag;
	wire nack_src      = nack_detect_flag | arb_lost_flag | sync_overrun;
	wire error_en      = rx_full_irq_en | nack_irq_en;
	wire capture_ack   = ack_slot & tx_mode;
	wire drive_ack     = ack_slot & ~tx_mode;

	wire [NUM_EV-1:0] req_src = {stop_detect_flag, nack_src, sync_overrun,
		rx_buf_full_flag, tx_end_flag, tx_buf_empty_flag};
	wire [NUM_EV-1:0] req_en  = {stop_detect_irq_en, nack_irq_en, error_en,
		rx_full_irq_en, tx_end_irq_en, tx_empty_irq_en};
	wire [NUM_EV-1:0] req_vec;

	// ----------------------------------------
	// request gates
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NUM_EV; gi++) begin : g_req
			req_gate u_gate (
				.clock  (clock),
				.rst_n  (rst_n),
				.flag   (req_src[gi]),
				.enable (req_en[gi]),
				.req    (req_vec[gi])
			);
		end
	endgenerate

	if (DATA_W < NUM_EV) begin : g_bad_width
		$error("event bits do not fit the register width");
	end

	assign tx_empty_req    = req_vec[EV_TX_EMPTY];
	assign tx_end_req      = req_vec[EV_TX_END];
	assign rx_full_req     = req_vec[EV_RX_FULL];
	assign error_req       = req_vec[EV_ERROR];
	assign nack_req        = req_vec[EV_NACK];
	assign stop_detect_req = req_vec[EV_STOP];

	// ----------------------------------------
	// control register next value
	// ----------------------------------------
	wire [7:0] ctrl_written = (ctrl_reg & ~CTRL_WR_MASK) | (reg_wdata & CTRL_WR_MASK);
	wire [7:0] ctrl_base    = wr_ctrl ? ctrl_written : ctrl_reg;
	wire [7:0] ack_bit      = 8'h01 << BIT_RX_ACK;
	assign ctrl_next = capture_ack ? ((ctrl_base & ~ack_bit) | ({8{sda_sync_reg}} & ack_bit))
		: ctrl_base;

	// ----------------------------------------
	// event status: set wins over write-one clear
	// ----------------------------------------
	wire [NUM_EV-1:0] ev_rise  = req_vec & ~req_prev_reg;
	wire [NUM_EV-1:0] ev_clear = wr_status ? reg_wdata[NUM_EV-1:0] : EV_RESET;
	assign ev_status_next = (ev_status_reg & ~ev_clear) | ev_rise;
	assign ev_mask_next   = wr_mask ? reg_wdata[NUM_EV-1:0] : ev_mask_reg;
	wire irq_next = |(ev_status_next & ev_mask_next);

	// ----------------------------------------
	// read data
	// ----------------------------------------
	wire [DATA_W-1:0] rd_ctrl   = ctrl_reg;
	function automatic logic [DATA_W-1:0] pad_ev(input logic [NUM_EV-1:0] v);
		pad_ev = {{(DATA_W-NUM_EV){1'b0}}, v};
	endfunction : pad_ev

	wire [DATA_W-1:0] rd_status = pad_ev(ev_status_reg);
	wire [DATA_W-1:0] rd_mask   = pad_ev(ev_mask_reg);
	assign rdata_next = !reg_rd    ? 8'h00 :
		hit_ctrl   ? rd_ctrl :
		hit_status ? rd_status :
		hit_mask   ? rd_mask : 8'h00;

	// ----------------------------------------
	// acknowledge handling
	// ----------------------------------------
	wire halt_next = ack_judge_sel & rx_ack_value;
	wire oe_n_next = ~(drive_ack & ~tx_ack_value);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ctrl_reg <= CTRL_RESET;
			ev_status_reg <= EV_RESET;
			ev_mask_reg <= EV_RESET;
			req_prev_reg <= EV_RESET;
		end else begin
			ctrl_reg <= ctrl_next;
			ev_status_reg <= ev_status_next;
			ev_mask_reg <= ev_mask_next;
			req_prev_reg <= req_vec;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sda_meta_reg <= 1'b1;
			sda_sync_reg <= 1'b1;
		end else begin
			sda_meta_reg <= sda_in;
			sda_sync_reg <= sda_meta_reg;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
			irq <= 1'b0;
			halt_transfer <= 1'b0;
			sda_oe_n <= 1'b1;
			sda_out <= 1'b0;
		end else begin
			reg_rdata <= rdata_next;
			irq <= irq_next;
			halt_transfer <= halt_next;
			sda_oe_n <= oe_n_next;
			sda_out <= 1'b0;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	tx_empty_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
		tx_buf_empty_flag && !ctrl_reg[BIT_TX_EMPTY_EN] |=> !tx_empty_req)
		else $error("transmit-empty request raised while disabled");

	tx_empty_on_a: assert property (@(posedge clock) disable iff (!rst_n)
		tx_buf_empty_flag && ctrl_reg[BIT_TX_EMPTY_EN] |=> tx_empty_req)
		else $error("transmit-empty request missing");

	tx_empty_off_a: assert property (@(posedge clock) disable iff (!rst_n)
		!tx_buf_empty_flag |=> !tx_empty_req)
		else $error("transmit-empty request without flag");

	tx_end_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
		tx_end_flag && ctrl_reg[BIT_TX_END_EN] |=> tx_end_req)
		else $error("transmit-end request missing");

	tx_end_drop_a: assert property (@(posedge clock) disable iff (!rst_n)
		tx_end_req && (!tx_end_flag || !ctrl_reg[BIT_TX_END_EN]) |=> !tx_end_req)
		else $error("transmit-end request not withdrawn");

	tx_end_off_a: assert property (@(posedge clock) disable iff (!rst_n)
		!tx_end_flag |=> !tx_end_req)
		else $error("transmit-end request without flag");

	rx_full_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
		rx_buf_full_flag && ctrl_reg[BIT_RX_FULL_EN] |=> rx_full_req)
		else $error("receive-full request missing");

	rx_full_en_a: assert property (@(posedge clock) disable iff (!rst_n)
		!ctrl_reg[BIT_RX_FULL_EN] |=> !rx_full_req)
		else $error("receive-full request raised while disabled");

	overrun_error_a: assert property (@(posedge clock) disable iff (!rst_n)
		(sync_mode && overrun_flag && ctrl_reg[BIT_RX_FULL_EN]) |=> error_req)
		else $error("overrun error request missing");

	overrun_async_a: assert property (@(posedge clock) disable iff (!rst_n)
		!sync_mode |=> !error_req)
		else $error("error request outside synchronous format");

	error_off_a: assert property (@(posedge clock) disable iff (!rst_n)
		!ctrl_reg[BIT_RX_FULL_EN] && !ctrl_reg[BIT_NACK_EN] |=> !error_req)
		else $error("error request raised while disabled");

	rx_full_drop_a: assert property (@(posedge clock) disable iff (!rst_n)
		rx_full_req && (!rx_buf_full_flag || !ctrl_reg[BIT_RX_FULL_EN]) |=> !rx_full_req)
		else $error("receive-full request not withdrawn");

	rx_full_off_a: assert property (@(posedge clock) disable iff (!rst_n)
		!rx_buf_full_flag |=> !rx_full_req)
		else $error("receive-full request without flag");

	nack_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
		(nack_detect_flag || arb_lost_flag) && ctrl_reg[BIT_NACK_EN] |=> nack_req)
		else $error("nack request missing");

	error_nack_en_a: assert property (@(posedge clock) disable iff (!rst_n)
		sync_mode && overrun_flag && ctrl_reg[BIT_NACK_EN] |=> error_req)
		else $error("overrun error request missing with nack enable");

	nack_overrun_a: assert property (@(posedge clock) disable iff (!rst_n)
		sync_mode && overrun_flag && ctrl_reg[BIT_NACK_EN] |=> nack_req)
		else $error("nack request missing on overrun");

	nack_drop_a: assert property (@(posedge clock) disable iff (!rst_n)
		!ctrl_reg[BIT_NACK_EN] |=> !nack_req)
		else $error("nack request not withdrawn");

	nack_flags_a: assert property (@(posedge clock) disable iff (!rst_n)
		!nack_detect_flag && !arb_lost_flag && !overrun_flag |=> !nack_req)
		else $error("nack request without source flag");

	stop_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
		stop_detect_flag |=> (stop_detect_req == $past(ctrl_reg[BIT_STOP_EN])))
		else $error("stop-detect request does not follow enable");

	stop_off_a: assert property (@(posedge clock) disable iff (!rst_n)
		!stop_detect_flag |=> !stop_detect_req)
		else $error("stop-detect request without flag");

	halt_judge_a: assert property (@(posedge clock) disable iff (!rst_n)
		ctrl_reg[BIT_ACK_JUDGE] && ctrl_reg[BIT_RX_ACK] |=> halt_transfer)
		else $error("transfer not halted on ack one");

	halt_ignore_a: assert property (@(posedge clock) disable iff (!rst_n)
		!ctrl_reg[BIT_ACK_JUDGE] |=> !halt_transfer)
		else $error("transfer halted with judgment off");

	halt_off_a: assert property (@(posedge clock) disable iff (!rst_n)
		!ctrl_reg[BIT_RX_ACK] |=> !halt_transfer)
		else $error("transfer halted on ack zero");

	ack_capture_a: assert property (@(posedge clock) disable iff (!rst_n)
		ack_slot && tx_mode |=> ctrl_reg[BIT_RX_ACK] == $past(sda_sync_reg))
		else $error("received ack not captured");

	ack_readonly_a: assert property (@(posedge clock) disable iff (!rst_n)
		!(ack_slot && tx_mode) |=> $stable(ctrl_reg[BIT_RX_ACK]))
		else $error("received ack bit changed without capture");

	ack_drive_a: assert property (@(posedge clock) disable iff (!rst_n)
		ack_slot && !tx_mode |=> sda_oe_n == $past(ctrl_reg[BIT_TX_ACK]))
		else $error("ack slot drive wrong");

	ack_release_a: assert property (@(posedge clock) disable iff (!rst_n)
		!(ack_slot && !tx_mode) |=> sda_oe_n)
		else $error("sda driven outside ack slot");

	ack_bt_write_a: assert property (@(posedge clock) disable iff (!rst_n)
		wr_ctrl |=> ctrl_reg[BIT_TX_ACK] == $past(reg_wdata[BIT_TX_ACK]))
		else $error("transmit ack bit not written");

	event_set_a: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(tx_end_req) |=> ev_status_reg[EV_TX_END])
		else $error("event status bit not set");

	event_sticky_a: assert property (@(posedge clock) disable iff (!rst_n)
		ev_status_reg[EV_TX_END] && !(wr_status && reg_wdata[EV_TX_END])
		|=> ev_status_reg[EV_TX_END])
		else $error("event status bit not sticky");

	irq_level_a: assert property (@(posedge clock) disable iff (!rst_n)
		irq == |(ev_status_reg & ev_mask_reg))
		else $error("interrupt line does not follow status and mask");

	enable_write_a: assert property (@(posedge clock) disable iff (!rst_n)
		wr_ctrl |=> ctrl_reg[BIT_TX_EMPTY_EN:BIT_ACK_JUDGE]
		== $past(reg_wdata[BIT_TX_EMPTY_EN:BIT_ACK_JUDGE]))
		else $error("enable bits not written");

	enable_reset_a: assert property (@(posedge clock)
		!rst_n |=> ctrl_reg == CTRL_RESET)
		else $error("enable bits not cleared by reset");

endmodule : i2c_irq_enable_gating

`default_nettype wire

// ==== irq_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// interrupt controller model
// ----------------------------------------
module irq_ctrl_model (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic [5:0] req_lines,
	input  wire logic       irq,
	output var  logic [5:0] taken,
	output var  logic       irq_seen
);
	// latches every request level and the summary line it has seen
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			taken    <= 6'h00;
			irq_seen <= 1'b0;
		end else begin
			taken    <= taken | req_lines;
			irq_seen <= irq_seen | irq;
		end
	end
endmodule : irq_ctrl_model
`default_nettype wire

// ==== tb_i2c_irq_enable_gating.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_irq_enable_gating
	import i2c_irq_pkg::*;
;
	logic              clock, rst_n, reg_wr, reg_rd, sync_mode, tx_mode, ack_slot, remote_sda;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata, reg_rdata, d, c;
	logic [6:0]        fl, nf;
	logic              ns, sda_out, sda_oe_n, halt_transfer, irq, irq_seen;
	logic [5:0]        req, e, seen;
	wire logic         sda_in;
	int                n_errors, checks;
	// open-drain level of the data line
	assign sda_in = (sda_oe_n | sda_out) & remote_sda;
	i2c_irq_enable_gating dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.tx_buf_empty_flag(fl[0]), .tx_end_flag(fl[1]), .rx_buf_full_flag(fl[2]),
		.nack_detect_flag(fl[3]), .arb_lost_flag(fl[4]), .overrun_flag(fl[5]),
		.stop_detect_flag(fl[6]), .sync_mode(sync_mode), .tx_mode(tx_mode),
		.ack_slot(ack_slot), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.halt_transfer(halt_transfer), .tx_empty_req(req[0]), .tx_end_req(req[1]),
		.rx_full_req(req[2]), .error_req(req[3]), .nack_req(req[4]),
		.stop_detect_req(req[5]), .irq(irq));
	irq_ctrl_model cpu (.clock(clock), .rst_n(rst_n), .req_lines(req), .irq(irq),
		.taken(seen), .irq_seen(irq_seen));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [5:0] exp_req(input logic [6:0] f, input logic [7:0] en,
		input logic s);
		exp_req[0] = f[0] & en[7];
		exp_req[1] = f[1] & en[6];
		exp_req[2] = f[2] & en[5];
		exp_req[3] = s & f[5] & (en[5] | en[4]);
		exp_req[4] = (f[3] | f[4] | (s & f[5])) & en[4];
		exp_req[5] = f[6] & en[3];
	endfunction : exp_req
	task automatic chk(input logic [7:0] s, input logic [7:0] x);
		checks++;
		if (s !== x) begin
			n_errors++;
			$display("mismatch at %0t: got %h exp %h", $time, s, x);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clock);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clock);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : tick
	task automatic finish_test;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test
	// ----------------------------------------
	// clock, watchdog, tests
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	initial begin
		repeat (20000) @(posedge clock);
		n_errors++;
		finish_test;
	end
	initial begin
		rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 8'h00;
		fl = 7'h00; sync_mode = 1'b0; tx_mode = 1'b0; ack_slot = 1'b0; remote_sda = 1'b1;
		n_errors = 0;
		checks = 0;
		void'($urandom(24));
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			rd(4'(i * 4), d);
			chk(d, 8'h00);
		end
		chk({2'b00, req}, 8'h00);
		wr(ADDR_CTRL, 8'hff);
		rd(ADDR_CTRL, d);
		chk(d, 8'hfd);
		wr(4'hc, 8'hff);
		rd(4'hc, d);
		chk(d, 8'h00);
		// random flags and enables
		for (int i = 0; i < 60; i++) begin
			@(posedge clock);
			fl <= 7'h00;
			c = 8'($urandom()) & 8'hf8;
			nf = 7'($urandom());
			ns = 1'($urandom());
			wr(ADDR_CTRL, c);
			@(posedge clock);
			fl <= nf;
			sync_mode <= ns;
			tick(2);
			e = exp_req(nf, c, ns);
			chk({2'b00, req}, {2'b00, e});
		end
		// withdrawal by enable and by flag
		@(posedge clock);
		fl <= 7'h7f;
		sync_mode <= 1'b1;
		wr(ADDR_CTRL, 8'hf8);
		tick(2);
		chk({2'b00, req}, 8'h3f);
		wr(ADDR_CTRL, 8'h00);
		tick(1);
		chk({2'b00, req}, 8'h00);
		wr(ADDR_CTRL, 8'hf8);
		@(posedge clock);
		fl <= 7'h00;
		tick(2);
		chk({2'b00, req}, 8'h00);
		// status, mask and interrupt line
		wr(ADDR_EV_STATUS, 8'h3f);
		rd(ADDR_EV_STATUS, d);
		chk(d, 8'h00);
		wr(ADDR_EV_MASK, 8'h04);
		@(posedge clock);
		fl <= 7'h01;
		tick(4);
		chk({7'h00, irq}, 8'h00);
		rd(ADDR_EV_STATUS, d);
		chk(d, 8'h01);
		@(posedge clock);
		fl <= 7'h04;
		tick(4);
		chk({7'h00, irq}, 8'h01);
		wr(ADDR_EV_MASK, 8'h00);
		tick(2);
		chk({7'h00, irq}, 8'h00);
		wr(ADDR_EV_MASK, 8'h04);
		@(posedge clock);
		fl <= 7'h00;
		tick(2);
		chk({7'h00, irq}, 8'h01);
		wr(ADDR_EV_STATUS, 8'h04);
		tick(2);
		chk({7'h00, irq}, 8'h00);
		rd(ADDR_EV_STATUS, d);
		chk(d, 8'h01);
		// received acknowledge and halt
		for (int k = 0; k < 2; k++) begin
			wr(ADDR_CTRL, 8'h04);
			@(posedge clock);
			tx_mode <= 1'b1;
			remote_sda <= (k == 0);
			ack_slot <= 1'b1;
			tick(4);
			@(posedge clock);
			ack_slot <= 1'b0;
			tick(2);
			rd(ADDR_CTRL, d);
			chk(d, (k == 0) ? 8'h06 : 8'h04);
			chk({7'h00, halt_transfer}, (k == 0) ? 8'h01 : 8'h00);
			wr(ADDR_CTRL, 8'h00);
			rd(ADDR_CTRL, d);
			chk(d, (k == 0) ? 8'h02 : 8'h00);
			chk({7'h00, halt_transfer}, 8'h00);
		end
		// transmitted acknowledge in receive mode
		for (int k = 0; k < 2; k++) begin
			@(posedge clock);
			tx_mode <= 1'b0;
			remote_sda <= 1'b1;
			wr(ADDR_CTRL, 8'(k));
			@(posedge clock);
			ack_slot <= 1'b1;
			@(posedge clock);
			ack_slot <= 1'b0;
			#1 chk({6'h00, sda_oe_n, sda_out}, (k == 0) ? 8'h00 : 8'h02);
			tick(1);
			chk({7'h00, sda_oe_n}, 8'h01);
		end
		chk({2'b00, seen}, 8'h3f);
		chk({7'h00, irq_seen}, 8'h01);
		finish_test;
	end
endmodule : tb_i2c_irq_enable_gating
`default_nettype wire
